// [sfs_pkg.sv]
// sfs_pkg: constants, register map and carrier types of the system fault status word.
// assumes one 200 MHz clock, a synchronous active-high reset and a plain register port.

package sfs_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_FAULT_WORD = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL    = 8'h10;
    localparam logic [7:0] ADDR_SNAPSHOT   = 8'h14;

    // control register fields and reset values
    localparam int          CTRL_RESET_CMD_BIT = 0;
    localparam int          CTRL_MONITOR_BIT   = 1;
    localparam logic        CTRL_MONITOR_RESET = 1'b1;
    localparam logic [15:0] IRQ_ENABLE_RESET   = 16'h0000;
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int UNIT_SLOTS   = 8;
    localparam int SYNC_WIDTH   = 24;
    localparam int CLK_MHZ      = 200;
    localparam int CLK_LOSS_NS  = 20000;
    localparam int CLK_LOSS_CYC = (CLK_LOSS_NS * CLK_MHZ) / 1000;
    localparam int SETTLE_CYC   = 8;

    // field positions inside the synchronised pin vector
    localparam int PIN_UNITS     = 0;
    localparam int PIN_COVER     = 8;
    localparam int PIN_ERR_CODE  = 9;
    localparam int PIN_FLASH     = 12;
    localparam int PIN_BUFFER    = 13;
    localparam int PIN_ABORT     = 14;
    localparam int PIN_PHASE     = 15;
    localparam int PIN_SERVO     = 16;
    localparam int PIN_DEFAULT   = 17;
    localparam int PIN_FILE      = 18;
    localparam int PIN_HW_MISM   = 19;
    localparam int PIN_SETTINGS  = 20;
    localparam int PIN_PROJECT   = 21;
    localparam int PIN_WDT_RTI   = 22;
    localparam int PIN_WDT_BG    = 23;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [15:0] unused_high;
        logic        unit_config_changed;
        logic [2:0]  unit_config_error_code;
        logic        program_flash_overflow;
        logic        buffer_ram_overflow;
        logic        global_abort_stop;
        logic        missing_motion_clocks;
        logic        factory_default;
        logic        system_file_error;
        logic        saved_hw_mismatch;
        logic        saved_settings_error;
        logic        project_load_error;
        logic        startup_read_fault;
        logic [1:0]  software_watchdog_fault;
    } sfs_fault_word_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sfs_reg_req_t;

    typedef enum logic [1:0] {
        MON_SETTLE = 2'b00,
        MON_SNAP   = 2'b01,
        MON_WATCH  = 2'b10
    } sfs_mon_state_t;

endpackage

// [sfs_fault_word.sv]
// sfs_fault_word: system fault status word with config monitor, interrupt and register port.
// assumes all fault pins are asynchronous to sys_clk and the bus master never overlaps strobes.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.

`timescale 1ns/100ps
`default_nettype none

module sfs_fault_word (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire sfs_pkg::sfs_reg_req_t reg_req,
    output var  logic [31:0]          rd_data,
    output var  logic                 rd_valid,
    output var  logic [31:0]          status_word,
    output var  logic                 irq,
    input  wire logic [7:0]           unit_present,
    input  wire logic                 end_cover_present,
    input  wire logic [2:0]           unit_config_error_code,
    input  wire logic                 program_flash_overflow,
    input  wire logic                 buffer_ram_overflow,
    input  wire logic                 global_abort_stop,
    input  wire logic                 phase_clock,
    input  wire logic                 servo_clock,
    input  wire logic                 factory_default,
    input  wire logic                 system_file_error,
    input  wire logic                 saved_hw_mismatch,
    input  wire logic                 saved_settings_error,
    input  wire logic                 project_load_error,
    input  wire logic                 rti_watchdog_timeout,
    input  wire logic                 bg_watchdog_timeout
);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [sfs_pkg::SYNC_WIDTH-1:0] pin_raw;
    logic [sfs_pkg::SYNC_WIDTH-1:0] pin_meta;
    logic [sfs_pkg::SYNC_WIDTH-1:0] pin_sync;

    // gather every outside pin into one vector
    assign pin_raw = {bg_watchdog_timeout, rti_watchdog_timeout, project_load_error,
                      saved_settings_error, saved_hw_mismatch, system_file_error,
                      factory_default, servo_clock, phase_clock, global_abort_stop,
                      buffer_ram_overflow, program_flash_overflow, unit_config_error_code,
                      end_cover_present, unit_present};

    // two flops per bit; the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < sfs_pkg::SYNC_WIDTH; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // register port decode
    // ****************************************************************
    logic        wr_clear;
    logic        wr_enable;
    logic        wr_control;
    logic        reset_cmd;
    logic        monitor_on;
    logic [15:0] irq_enable;

    // status word address is deliberately absent: writes there fall through
    always_comb begin
        wr_clear   = 1'b0;
        wr_enable  = 1'b0;
        wr_control = 1'b0;
        if (reg_req.wr && reg_req.addr == sfs_pkg::ADDR_IRQ_CLEAR) begin
            wr_clear = 1'b1;
        end else if (reg_req.wr && reg_req.addr == sfs_pkg::ADDR_IRQ_ENABLE) begin
            wr_enable = 1'b1;
        end else if (reg_req.wr && reg_req.addr == sfs_pkg::ADDR_CONTROL) begin
            wr_control = 1'b1;
        end
    end

    // reset command is a one-cycle pulse; monitor enable is a held level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reset_cmd  <= 1'b0;
            monitor_on <= sfs_pkg::CTRL_MONITOR_RESET;
        end else begin
            reset_cmd <= wr_control && reg_req.wdata[sfs_pkg::CTRL_RESET_CMD_BIT];
            if (wr_control) begin
                monitor_on <= reg_req.wdata[sfs_pkg::CTRL_MONITOR_BIT];
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_enable <= sfs_pkg::IRQ_ENABLE_RESET;
        end else if (wr_enable) begin
            irq_enable <= reg_req.wdata[15:0];
        end
    end

    // ****************************************************************
    // expansion unit configuration monitor
    // ****************************************************************
    sfs_pkg::sfs_mon_state_t mon_state;
    logic [3:0]              settle_cnt;
    logic [8:0]              config_snapshot;
    logic [8:0]              config_now;
    logic                    config_differs;
    logic                    unit_config_changed;

    assign config_now     = pin_sync[sfs_pkg::PIN_COVER:sfs_pkg::PIN_UNITS];
    assign config_differs = (config_now != config_snapshot);

    // settle lets synchronisers fill before the reference is taken
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mon_state  <= sfs_pkg::MON_SETTLE;
            settle_cnt <= 4'h0;
        end else begin
            case (mon_state)
                sfs_pkg::MON_SETTLE: begin
                    settle_cnt <= settle_cnt + 4'h1;
                    if (settle_cnt == 4'(sfs_pkg::SETTLE_CYC - 1)) begin
                        mon_state <= sfs_pkg::MON_SNAP;
                    end
                end
                sfs_pkg::MON_SNAP: begin
                    mon_state <= sfs_pkg::MON_WATCH;
                end
                sfs_pkg::MON_WATCH: begin
                    settle_cnt <= 4'h0;
                end
                default: begin
                    mon_state <= sfs_pkg::MON_SETTLE;
                end
            endcase
        end
    end

    // reference configuration; a reset command re-takes it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            config_snapshot <= 9'h000;
        end else if (mon_state == sfs_pkg::MON_SNAP || reset_cmd) begin
            config_snapshot <= config_now;
        end
    end

    // sticky change flag; a change seen in the clear cycle still wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            unit_config_changed <= 1'b0;
        end else if (mon_state == sfs_pkg::MON_WATCH && monitor_on && config_differs) begin
            unit_config_changed <= 1'b1;
        end else if (reset_cmd) begin
            unit_config_changed <= 1'b0;
        end
    end

    // ****************************************************************
    // motion clock loss detection
    // ****************************************************************
    logic [1:0]  clk_prev;
    logic [1:0]  clk_now;
    logic [1:0]  clk_lost;
    logic [11:0] loss_cnt [2];

    assign clk_now = {pin_sync[sfs_pkg::PIN_SERVO], pin_sync[sfs_pkg::PIN_PHASE]};

    // one watchdog counter per motion clock, restarted on every edge
    genvar ci;
    generate
        for (ci = 0; ci < 2; ci++) begin : g_clk
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    clk_prev[ci] <= 1'b0;
                    loss_cnt[ci] <= 12'h000;
                    clk_lost[ci] <= 1'b0;
                end else begin
                    clk_prev[ci] <= clk_now[ci];
                    if (clk_prev[ci] != clk_now[ci]) begin
                        loss_cnt[ci] <= 12'h000;
                        clk_lost[ci] <= 1'b0;
                    end else if (loss_cnt[ci] == 12'(sfs_pkg::CLK_LOSS_CYC - 1)) begin
                        clk_lost[ci] <= 1'b1;
                    end else begin
                        loss_cnt[ci] <= loss_cnt[ci] + 12'h001;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // load errors and watchdog faults
    // ****************************************************************
    logic       file_err;
    logic       hw_mismatch;
    logic       settings_err;
    logic       project_err;
    logic [1:0] wdt_fault;

    // load errors latch: the loader reports them once at start-up
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            file_err     <= 1'b0;
            hw_mismatch  <= 1'b0;
            settings_err <= 1'b0;
            project_err  <= 1'b0;
        end else begin
            file_err     <= file_err     | pin_sync[sfs_pkg::PIN_FILE];
            hw_mismatch  <= hw_mismatch  | pin_sync[sfs_pkg::PIN_HW_MISM];
            settings_err <= settings_err | pin_sync[sfs_pkg::PIN_SETTINGS];
            project_err  <= project_err  | pin_sync[sfs_pkg::PIN_PROJECT];
        end
    end

    // watchdog timeouts stick so a short pulse is never missed
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wdt_fault <= 2'b00;
        end else begin
            wdt_fault[1] <= wdt_fault[1] | pin_sync[sfs_pkg::PIN_WDT_RTI];
            wdt_fault[0] <= wdt_fault[0] | pin_sync[sfs_pkg::PIN_WDT_BG];
        end
    end

    // ****************************************************************
    // status word assembly
    // ****************************************************************
    sfs_pkg::sfs_fault_word_t next_word;

    // plain flops only, no retention: cleared by reset, lost with power
    always_comb begin
        next_word                         = '0;
        next_word.unused_high             = 16'h0000;
        next_word.unit_config_changed     = unit_config_changed;
        next_word.unit_config_error_code  =
            pin_sync[sfs_pkg::PIN_ERR_CODE+2:sfs_pkg::PIN_ERR_CODE];
        next_word.program_flash_overflow  = pin_sync[sfs_pkg::PIN_FLASH];
        next_word.buffer_ram_overflow     = pin_sync[sfs_pkg::PIN_BUFFER];
        next_word.global_abort_stop       = pin_sync[sfs_pkg::PIN_ABORT];
        next_word.missing_motion_clocks   = |clk_lost;
        next_word.factory_default         = pin_sync[sfs_pkg::PIN_DEFAULT];
        next_word.system_file_error       = file_err;
        next_word.saved_hw_mismatch       = hw_mismatch;
        next_word.saved_settings_error    = settings_err;
        next_word.project_load_error      = project_err;
        next_word.startup_read_fault      =
            file_err | hw_mismatch | settings_err | project_err;
        next_word.software_watchdog_fault = wdt_fault;
    end

    // the published word; the bus reads it at ADDR_FAULT_WORD and cannot write it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_word <= 32'h0000_0000;
        end else begin
            status_word <= next_word;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    logic [15:0] word_prev;
    logic [15:0] word_rise;
    logic [15:0] irq_status;

    assign word_rise = status_word[15:0] & ~word_prev;

    // rising edge of any defined status bit is an event
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            word_prev <= 16'h0000;
        end else begin
            word_prev <= status_word[15:0];
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_status <= 16'h0000;
        end else if (wr_clear) begin
            irq_status <= (irq_status & ~reg_req.wdata[15:0]) | word_rise;
        end else begin
            irq_status <= irq_status | word_rise;
        end
    end

    // level output, registered so it never glitches
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [31:0] next_rd_data;

    // unmapped addresses and the write-only clear read as zero
    always_comb begin
        next_rd_data = sfs_pkg::READ_ZERO;
        if (reg_req.addr == sfs_pkg::ADDR_FAULT_WORD) begin
            next_rd_data = status_word;
        end else if (reg_req.addr == sfs_pkg::ADDR_IRQ_STATUS) begin
            next_rd_data = {16'h0000, irq_status};
        end else if (reg_req.addr == sfs_pkg::ADDR_IRQ_ENABLE) begin
            next_rd_data = {16'h0000, irq_enable};
        end else if (reg_req.addr == sfs_pkg::ADDR_CONTROL) begin
            next_rd_data = {30'h0000_0000, monitor_on, 1'b0};
        end else if (reg_req.addr == sfs_pkg::ADDR_SNAPSHOT) begin
            next_rd_data = {23'h00_0000, config_snapshot};
        end
    end

    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_data  <= 32'h0000_0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= reg_req.rd;
            rd_data  <= reg_req.rd ? next_rd_data : sfs_pkg::READ_ZERO;
        end
    end

endmodule

`default_nettype wire

// [sfs_fault_word_monitor.sv]
// sfs_fault_word_monitor: concurrent checks on the fault word ports.
// assumes one sys_clk domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module sfs_fault_word_monitor (
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire sfs_pkg::sfs_reg_req_t reg_req,
    input wire logic [31:0]           rd_data,
    input wire logic                  rd_valid,
    input wire logic [31:0]           status_word,
    input wire logic                  irq,
    input wire logic [7:0]            unit_present,
    input wire logic                  end_cover_present,
    input wire logic [2:0]            unit_config_error_code,
    input wire logic                  program_flash_overflow,
    input wire logic                  buffer_ram_overflow,
    input wire logic                  global_abort_stop,
    input wire logic                  phase_clock,
    input wire logic                  servo_clock,
    input wire logic                  system_file_error,
    input wire logic                  saved_hw_mismatch,
    input wire logic                  saved_settings_error,
    input wire logic                  project_load_error,
    input wire logic                  rti_watchdog_timeout,
    input wire logic                  bg_watchdog_timeout
);
    // ************************************************************
    // helper logic
    // ************************************************************
    logic [7:0]  rst_age;
    logic [7:0]  chg_age;
    logic [7:0]  cmd_age;
    logic [12:0] stall_ph;
    logic [12:0] stall_sv;
    logic        prev_ph;
    logic        prev_sv;
    logic [8:0]  prev_pres;
    logic [2:0]  live_pins;
    logic [3:0]  lat_pins;
    logic [1:0]  wdt_pins;
    logic        fault_rd;

    // pin groups for the past functions
    assign live_pins = {program_flash_overflow, buffer_ram_overflow, global_abort_stop};
    assign lat_pins  = {system_file_error, saved_hw_mismatch, saved_settings_error,
                        project_load_error};
    assign wdt_pins  = {rti_watchdog_timeout, bg_watchdog_timeout};
    assign fault_rd  = reg_req.rd && (reg_req.addr == sfs_pkg::ADDR_FAULT_WORD);

    // saturating ages since reset, presence change, reset command
    always_ff @(posedge sys_clk) begin
        prev_pres <= {end_cover_present, unit_present};
        if (reset) begin
            rst_age <= 8'h00;
            chg_age <= 8'hFF;
            cmd_age <= 8'hFF;
        end else begin
            rst_age <= rst_age + {7'h00, rst_age != 8'hFF};
            chg_age <= (prev_pres != {end_cover_present, unit_present}) ? 8'h00
                       : chg_age + {7'h00, chg_age != 8'hFF};
            cmd_age <= (reg_req.wr && reg_req.addr == sfs_pkg::ADDR_CONTROL && reg_req.wdata[0])
                       ? 8'h00 : cmd_age + {7'h00, cmd_age != 8'hFF};
        end
    end

    // cycles since an edge per motion clock; raw pins give sync slack
    always_ff @(posedge sys_clk) begin
        prev_ph <= phase_clock;
        prev_sv <= servo_clock;
        if (reset) begin
            stall_ph <= 13'h0000;
            stall_sv <= 13'h0000;
        end else begin
            stall_ph <= (phase_clock != prev_ph) ? 13'h0000 : stall_ph + {12'h000, ~&stall_ph};
            stall_sv <= (servo_clock != prev_sv) ? 13'h0000 : stall_sv + {12'h000, ~&stall_sv};
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    upper_zero_a: assert property (status_word[31:16] == 16'h0000)
        else $error("upper status bits not zero");
    load_or_a: assert property (status_word[2] == |status_word[6:3])
        else $error("load summary bit wrong");
    code_follow_a: assert property (rst_age > 8'h04 |->
        status_word[14:12] == $past(unit_config_error_code, 3))
        else $error("error code field not following pins");
    flags_follow_a: assert property (rst_age > 8'h04 |->
        status_word[11:9] == $past(live_pins, 3))
        else $error("live flags not following pins");
    load_latch_a: assert property (rst_age > 8'h05 |->
        ($past(lat_pins, 4) & ~status_word[6:3]) == 4'h0)
        else $error("load error not latched");
    wdt_latch_a: assert property (rst_age > 8'h05 |->
        ($past(wdt_pins, 4) & ~status_word[1:0]) == 2'h0)
        else $error("watchdog fault not latched");
    change_cause_a: assert property ($rose(status_word[15]) |-> chg_age <= 8'h08)
        else $error("change flag set without presence change");
    change_hold_a: assert property ($fell(status_word[15]) |-> cmd_age <= 8'h04)
        else $error("change flag cleared without reset command");
    clock_loss_a: assert property ($rose(status_word[8]) |->
        (stall_ph > 13'h0F96 || stall_sv > 13'h0F96))
        else $error("clock loss flagged too early");
    word_read_a: assert property (fault_rd |=> rd_valid &&
        rd_data == $past(status_word))
        else $error("fault word read data wrong");

    change_seen_c: cover property ($rose(status_word[15]));
    clock_lost_c: cover property ($rose(status_word[8]));
    irq_raised_c: cover property ($rose(irq));
endmodule

bind sfs_fault_word sfs_fault_word_monitor sfs_fault_word_monitor_i (.*);
`default_nettype wire

// [sfs_fault_word_test.sv]
// sfs_fault_word_test: self-checking bench for the system fault status word.
// assumes package and design compiled first; drives every pin itself.
`timescale 1ns/100ps
`default_nettype none

module sfs_fault_word_test;
    logic                  sys_clk;
    logic                  reset;
    sfs_pkg::sfs_reg_req_t reg_req;
    logic [31:0]           rd_data;
    logic                  rd_valid;
    logic [31:0]           status_word;
    logic                  irq;
    logic [7:0]            unit_present;
    logic                  end_cover_present;
    logic [6:0]            live;
    logic [5:0]            lat;
    logic                  phase_clock;
    logic                  servo_clock;
    logic                  clk_run;
    int                    error_cnt;
    int                    checks;
    logic [38:0]           rows [8];

    sfs_fault_word sfs_fault_word_i (
        .sys_clk, .reset, .reg_req, .rd_data, .rd_valid, .status_word, .irq,
        .unit_present, .end_cover_present, .phase_clock, .servo_clock,
        .unit_config_error_code(live[6:4]), .program_flash_overflow(live[3]),
        .buffer_ram_overflow(live[2]), .global_abort_stop(live[1]),
        .factory_default(live[0]), .system_file_error(lat[5]), .saved_hw_mismatch(lat[4]),
        .saved_settings_error(lat[3]), .project_load_error(lat[2]),
        .rti_watchdog_timeout(lat[1]), .bg_watchdog_timeout(lat[0])
    );

    // ************************************************************
    // clocks and tasks
    // ************************************************************
    // 200 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // motion clocks toggle unless stalled
    always @(posedge sys_clk) begin
        if (clk_run) begin
            phase_clock <= ~phase_clock;
            servo_clock <= ~servo_clock;
        end
    end

    task automatic results();
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    // data stands only in the cycle after the strobe, so look there
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.rd   <= 1'b1;
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk("read valid", 32'h1, {31'h0, rd_valid});
        chk("read data", exp, rd_data);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        reg_req.wr    <= 1'b1;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    // bounded wait; running out ends the run
    task automatic wait_bit(input int idx, input logic val, input int lim);
        int n;
        n = 0;
        while (status_word[idx] !== val && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("status bit", {31'h0, val}, {31'h0, status_word[idx]});
        if (status_word[idx] !== val) results();
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [5:0] acc;
        reset = 1'b1;
        reg_req = '0;
        unit_present = 8'h00;
        end_cover_present = 1'b0;
        live = 7'h00;
        lat = 6'h00;
        phase_clock = 1'b0;
        servo_clock = 1'b0;
        clk_run = 1'b1;
        error_cnt = 0;
        checks = 0;
        // {code, flash, buffer, abort, default} beside the word they give
        rows = '{{7'h00, 32'h0000_0000}, {7'h18, 32'h0000_1800}, {7'h24, 32'h0000_2400},
                 {7'h32, 32'h0000_3200}, {7'h41, 32'h0000_4080}, {7'h5C, 32'h0000_5C00},
                 {7'h63, 32'h0000_6280}, {7'h7F, 32'h0000_7E80}};
        do_reset();
        rd_chk(sfs_pkg::ADDR_CONTROL, {30'h0, sfs_pkg::CTRL_MONITOR_RESET, 1'b0});
        rd_chk(sfs_pkg::ADDR_IRQ_ENABLE, {16'h0000, sfs_pkg::IRQ_ENABLE_RESET});
        rd_chk(8'hFC, sfs_pkg::READ_ZERO);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            live <= rows[i][38:32];
            repeat (5) @(posedge sys_clk);
            #1;
            chk("live word", rows[i][31:0], status_word);
            rd_chk(sfs_pkg::ADDR_FAULT_WORD, rows[i][31:0]);
        end
        live <= 7'h00;
        // latched faults pile up and outlive their pins
        for (int i = 0; i < 6; i++) begin
            acc = (6'h02 << i) - 6'h01;
            @(posedge sys_clk);
            lat <= 6'h01 << i;
            repeat (2) @(posedge sys_clk);
            lat <= 6'h00;
            repeat (6) @(posedge sys_clk);
            #1;
            chk("latched", {25'h0, acc[5:2], |acc[5:2], acc[1:0]}, status_word);
        end
        wr(sfs_pkg::ADDR_FAULT_WORD, 32'hFFFF_FFFF);
        rd_chk(sfs_pkg::ADDR_FAULT_WORD, 32'h0000_007F);
        do_reset();
        chk("after reset", 32'h0000_0000, status_word);
        repeat (12) @(posedge sys_clk);
        #1;
        chk("no change yet", 32'h0, {31'h0, status_word[15]});
        wr(sfs_pkg::ADDR_IRQ_ENABLE, 32'h0000_8000);
        @(posedge sys_clk);
        unit_present <= 8'h01;
        wait_bit(15, 1'b1, 20);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("irq on", 32'h1, {31'h0, irq});
        rd_chk(sfs_pkg::ADDR_IRQ_STATUS, 32'h0000_8000);
        unit_present <= 8'h00;
        wr(sfs_pkg::ADDR_IRQ_CLEAR, 32'h0000_8000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("irq off", 32'h0, {31'h0, irq});
        chk("flag held", 32'h1, {31'h0, status_word[15]});
        wr(sfs_pkg::ADDR_CONTROL, 32'h0000_0003);
        wait_bit(15, 1'b0, 10);
        @(posedge sys_clk);
        end_cover_present <= 1'b1;
        wait_bit(15, 1'b1, 20);
        // stall motion clocks short of, then past, the loss count
        @(posedge sys_clk);
        clk_run <= 1'b0;
        repeat (3900) @(posedge sys_clk);
        #1;
        chk("clocks early", 32'h0, {31'h0, status_word[8]});
        wait_bit(8, 1'b1, 300);
        results();
    end
endmodule
`default_nettype wire
